// [hdl/srl_pkg.sv]
// ----------------------------------------------------------------------------
// register map and field layout
// ----------------------------------------------------------------------------
package srl_pkg;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_MAIN = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SRC = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;

  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] SRC_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // divided pulse: period is 2^(select + DIV_LOG2_MIN) oscillator cycles
  localparam int DIV_CNT_W = 9;
  localparam int DIV_LOG2_MIN = 2;

  typedef struct packed {
    logic latch_on;
    logic [2:0] pulse_divider_select;
    logic true_out_pin_enable;
    logic inv_out_pin_enable;
    logic sw_set_pulse;
    logic sw_reset_pulse;
  } srl_main_t;

  typedef struct packed {
    logic pin_set_enable;
    logic divclk_set_enable;
    logic cmp2_set_enable;
    logic cmp1_set_enable;
    logic pin_reset_enable;
    logic divclk_reset_enable;
    logic cmp2_reset_enable;
    logic cmp1_reset_enable;
  } srl_src_t;

  typedef enum {REG_MAIN, REG_SRC, REG_STAT, REG_NONE} srl_reg_t;

  function automatic srl_reg_t reg_sel(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFF_MAIN: reg_sel = REG_MAIN;
      OFF_SRC: reg_sel = REG_SRC;
      OFF_STAT: reg_sel = REG_STAT;
      default: reg_sel = REG_NONE;
    endcase
  endfunction : reg_sel

endpackage : srl_pkg

// [hdl/srl_pulse_div.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// periodic one-cycle pulse from the oscillator
// ----------------------------------------------------------------------------
module srl_pulse_div (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control
  input wire logic [2:0] sel_i,
  // pulse
  output logic pulse_o
);

  logic [srl_pkg::DIV_CNT_W-1:0] cnt_ff;
  logic [srl_pkg::DIV_CNT_W-1:0] mask;

  // free-running counter; every period divides the wrap, so a new select
  // never produces a pulse closer than the shortest period
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 9'h001;
    end
  end

  always_comb begin
    mask = ~({srl_pkg::DIV_CNT_W{1'b1}} <<
             (32'(sel_i) + srl_pkg::DIV_LOG2_MIN));
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= (cnt_ff & mask) == mask;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_pulse_spacing: assert property (
    pulse_o |=> !pulse_o [*3])
    else $error("divided pulse closer than four cycles");

  a_pulse_period_four: assert property (
    (pulse_o && sel_i == 3'h0) ##1 (sel_i == 3'h0) [*3] |=> pulse_o)
    else $error("divided pulse missed at period four");

  c_pulse_long: cover property (pulse_o && sel_i == 3'h7);

endmodule : srl_pulse_div

// [hdl/srl_latch_ctrl.sv]
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Operation
// - latch only acts while latch_on is one; otherwise it holds
// - divided pulse one cycle wide every 4 to 512 cycles by select
// - latch on and true enable drive latch state onto true pin
// - latch on and inverted enable drive complement onto inverted pin
// - latch off leaves both output pins undriven whatever the enables
// - writing one to software set pulses set input for one cycle
// - writing one to software reset pulses reset input for one cycle
// - software set and reset bits self-clear and always read zero
// - set and reset together leave the latch reset while latch_on is one
// - separate enables let divided pulse drive set and reset inputs
// - each comparator output enabled separately for set and for reset
module srl_latch_ctrl #(
  parameter bit TWO_CMP = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // axi4-lite write address
  input wire logic [srl_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [srl_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // latch sources
  input wire logic latch_input_pin_i,
  input wire logic cmp1_out_i,
  input wire logic cmp2_out_i,
  // output pins
  output logic true_out_pin_o,
  output logic true_out_pin_oe_o,
  output logic inv_out_pin_o,
  output logic inv_out_pin_oe_o
);

  srl_pkg::srl_main_t main_ff, wmain;
  srl_pkg::srl_src_t src_ff;
  logic [srl_pkg::ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff, aw_got_ff, w_got_ff, wr_do;
  logic sw_set_ff, sw_reset_ff, q_ff, div_pulse;
  logic set_in, reset_in, cmp2_en_set, cmp2_en_reset;

  // --------------------------------------------------------------------------
  // axi4-lite write path
  // --------------------------------------------------------------------------
  assign wr_do = aw_got_ff && w_got_ff && !s_axi_bvalid_o;
  assign wmain = wdata_ff;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_axi_awready_o <= 1'b0;
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr_i;
    end else begin
      if (wr_do) begin
        aw_got_ff <= 1'b0;
      end
      s_axi_awready_o <= !aw_got_ff && !s_axi_bvalid_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_axi_wready_o <= 1'b0;
      w_got_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata_i[7:0];
      wstrb_ff <= s_axi_wstrb_i[0];
    end else begin
      if (wr_do) begin
        w_got_ff <= 1'b0;
      end
      s_axi_wready_o <= !w_got_ff && !s_axi_bvalid_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= srl_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (srl_pkg::reg_sel(awaddr_ff) == srl_pkg::REG_NONE) ?
                       srl_pkg::RESP_DECERR : srl_pkg::RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      main_ff <= srl_pkg::MAIN_RST;
      src_ff <= srl_pkg::SRC_RST;
    end else if (wr_do && wstrb_ff) begin
      if (srl_pkg::reg_sel(awaddr_ff) == srl_pkg::REG_MAIN) begin
        main_ff <= wmain;
        main_ff.sw_set_pulse <= 1'b0;
        main_ff.sw_reset_pulse <= 1'b0;
      end
      if (srl_pkg::reg_sel(awaddr_ff) == srl_pkg::REG_SRC) begin
        src_ff <= wdata_ff;
      end
    end
  end

  // pulse bits are write-one only; a written zero leaves them idle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sw_set_ff <= 1'b0;
      sw_reset_ff <= 1'b0;
    end else begin
      sw_set_ff <= wr_do && wstrb_ff && wmain.sw_set_pulse &&
                   srl_pkg::reg_sel(awaddr_ff) == srl_pkg::REG_MAIN;
      sw_reset_ff <= wr_do && wstrb_ff && wmain.sw_reset_pulse &&
                     srl_pkg::reg_sel(awaddr_ff) == srl_pkg::REG_MAIN;
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite read path
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= srl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= srl_pkg::RESP_OKAY;
      case (srl_pkg::reg_sel(s_axi_araddr_i))
        srl_pkg::REG_MAIN: s_axi_rdata_o <= {24'h00_0000, main_ff};
        srl_pkg::REG_SRC: s_axi_rdata_o <= {24'h00_0000, src_ff};
        srl_pkg::REG_STAT: s_axi_rdata_o <= {31'h0000_0000, q_ff};
        default: begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= srl_pkg::RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // latch core
  // --------------------------------------------------------------------------
  srl_pulse_div u_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sel_i(main_ff.pulse_divider_select),
    .pulse_o(div_pulse)
  );

  assign cmp2_en_set = TWO_CMP && src_ff.cmp2_set_enable;
  assign cmp2_en_reset = TWO_CMP && src_ff.cmp2_reset_enable;

  assign set_in = sw_set_ff ||
                  (src_ff.pin_set_enable && latch_input_pin_i) ||
                  (src_ff.divclk_set_enable && div_pulse) ||
                  (src_ff.cmp1_set_enable && cmp1_out_i) ||
                  (cmp2_en_set && cmp2_out_i);
  assign reset_in = sw_reset_ff ||
                    (src_ff.pin_reset_enable && latch_input_pin_i) ||
                    (src_ff.divclk_reset_enable && div_pulse) ||
                    (src_ff.cmp1_reset_enable && cmp1_out_i) ||
                    (cmp2_en_reset && cmp2_out_i);

  // reset to zero only for a clean simulation; firmware must still force a
  // known state before enabling pins, as silicon would not
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q_ff <= 1'b0;
    end else if (main_ff.latch_on) begin
      if (reset_in) begin
        q_ff <= 1'b0;
      end else if (set_in) begin
        q_ff <= 1'b1;
      end
    end
  end

  // pins: data forced low when not driven
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      true_out_pin_o <= 1'b0;
      true_out_pin_oe_o <= 1'b0;
      inv_out_pin_o <= 1'b0;
      inv_out_pin_oe_o <= 1'b0;
    end else begin
      true_out_pin_oe_o <= main_ff.latch_on &&
                           main_ff.true_out_pin_enable;
      true_out_pin_o <= main_ff.latch_on &&
                        main_ff.true_out_pin_enable && q_ff;
      inv_out_pin_oe_o <= main_ff.latch_on &&
                          main_ff.inv_out_pin_enable;
      inv_out_pin_o <= main_ff.latch_on &&
                       main_ff.inv_out_pin_enable && !q_ff;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_latch_off_hold: assert property (
    !main_ff.latch_on |=> $stable(q_ff))
    else $error("latch changed while disabled");
  a_true_pin_drive: assert property (
    main_ff.latch_on && main_ff.true_out_pin_enable |=>
    true_out_pin_oe_o && true_out_pin_o == $past(q_ff))
    else $error("true pin does not follow latch");
  a_inv_pin_drive: assert property (
    main_ff.latch_on && main_ff.inv_out_pin_enable |=>
    inv_out_pin_oe_o && inv_out_pin_o == !$past(q_ff))
    else $error("inverted pin does not follow latch");
  a_pins_off_idle: assert property (
    !main_ff.latch_on |=> !true_out_pin_oe_o && !inv_out_pin_oe_o)
    else $error("pin driven while latch disabled");
  a_sw_set_once: assert property (
    wr_do && wstrb_ff && wmain.sw_set_pulse &&
    srl_pkg::reg_sel(awaddr_ff) == srl_pkg::REG_MAIN |=>
    sw_set_ff ##1 !sw_set_ff)
    else $error("software set pulse not one cycle");
  a_sw_reset_once: assert property (
    wr_do && wstrb_ff && wmain.sw_reset_pulse &&
    srl_pkg::reg_sel(awaddr_ff) == srl_pkg::REG_MAIN |=>
    sw_reset_ff ##1 !sw_reset_ff)
    else $error("software reset pulse not one cycle");
  a_pulse_bits_zero: assert property (
    s_axi_arvalid_i && s_axi_arready_o &&
    srl_pkg::reg_sel(s_axi_araddr_i) == srl_pkg::REG_MAIN |=>
    s_axi_rvalid_o && s_axi_rdata_o[1:0] == 2'h0)
    else $error("pulse bits read back nonzero");
  a_reset_dominant: assert property (
    main_ff.latch_on && set_in && reset_in |=> !q_ff)
    else $error("set won over reset");
  a_divclk_sets: assert property (
    main_ff.latch_on && src_ff.divclk_set_enable && div_pulse &&
    !reset_in |=> q_ff)
    else $error("divided pulse failed to set latch");
  a_cmp1_resets: assert property (
    main_ff.latch_on && src_ff.cmp1_reset_enable && cmp1_out_i |=> !q_ff)
    else $error("comparator one failed to reset latch");
  a_pin_sets: assert property (
    main_ff.latch_on && src_ff.pin_set_enable && latch_input_pin_i &&
    !reset_in |=> q_ff)
    else $error("input pin failed to set latch");
  a_cmp2_gated: assert property (
    !TWO_CMP && main_ff.latch_on && !q_ff && cmp2_out_i &&
    !sw_set_ff && !src_ff.pin_set_enable && !src_ff.divclk_set_enable &&
    !src_ff.cmp1_set_enable |=> !q_ff)
    else $error("second comparator acted on single variant");
  c_set_then_reset: cover property (
    main_ff.latch_on && sw_set_ff ##[1:20] sw_reset_ff);
  c_both_pins: cover property (true_out_pin_oe_o && inv_out_pin_oe_o);
  c_decerr_read: cover property (
    s_axi_rvalid_o && s_axi_rresp_o == srl_pkg::RESP_DECERR);

endmodule : srl_latch_ctrl

// [test/srl_far_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// far side: input pin and comparator outputs
// ----------------------------------------------------------------------------
module srl_far_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // requested levels: pin, comparator 2, comparator 1
  input wire logic [2:0] req_i,
  // source lines
  output logic latch_input_pin_o,
  output logic cmp2_out_o,
  output logic cmp1_out_o
);
  // sources move only at the clock edge, like a synchronised comparator
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      latch_input_pin_o <= 1'b0;
      cmp2_out_o <= 1'b0;
      cmp1_out_o <= 1'b0;
    end else begin
      latch_input_pin_o <= req_i[2];
      cmp2_out_o <= req_i[1];
      cmp1_out_o <= req_i[0];
    end
  end
endmodule : srl_far_model

// [test/set_reset_latch_control_tb.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// bench for the latch control block
// ----------------------------------------------------------------------------
module set_reset_latch_control_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [srl_pkg::ADDR_W-1:0] awaddr = 4'h0;
  logic [srl_pkg::ADDR_W-1:0] araddr = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] req = 3'h0;
  logic s_pin, s_c1, s_c2, tq, tqe, nq, nqe;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0;
  localparam logic [2:0] RQ [4] = '{3'h4, 3'h0, 3'h2, 3'h1};

  initial forever #50 clk_i = ~clk_i;

  srl_latch_ctrl i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .latch_input_pin_i(s_pin), .cmp1_out_i(s_c1), .cmp2_out_i(s_c2),
    .true_out_pin_o(tq), .true_out_pin_oe_o(tqe),
    .inv_out_pin_o(nq), .inv_out_pin_oe_o(nqe));

  // single-comparator variant on the same bus; its own checks watch cmp2
  srl_latch_ctrl #(.TWO_CMP(1'b0)) i_dut_one (.clk_i(clk_i),
    .rstn_i(rstn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(),
    .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(), .s_axi_rdata_o(), .s_axi_rresp_o(),
    .s_axi_rvalid_o(), .s_axi_rready_i(rready),
    .latch_input_pin_i(s_pin), .cmp1_out_i(s_c1), .cmp2_out_i(s_c2),
    .true_out_pin_o(), .true_out_pin_oe_o(),
    .inv_out_pin_o(), .inv_out_pin_oe_o());

  srl_far_model i_far (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req),
    .latch_input_pin_o(s_pin), .cmp2_out_o(s_c2), .cmp1_out_o(s_c1));

  // ----------------------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------------------
  task report_and_stop;
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task chk(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // hang guard: the divider sweep dominates the run time
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end

  // read answers are matched against the oldest note
  always @(posedge clk_i) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = exp_q.pop_front();
      chk({rresp, rdata}, e);
    end
  end

  // ----------------------------------------------------------------------------
  // bus and source drivers
  // ----------------------------------------------------------------------------
  task axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_d;
    logic w_d;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    while (!(aw_d && w_d)) begin
      @(posedge clk_i);
      if (awvalid && awready === 1'b1) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    chk({32'h0, bresp}, {32'h0, er});
    bready <= 1'b0;
    // pulse bits act two edges after the write lands
    repeat (3) @(posedge clk_i);
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk_i);
    exp_q.push_back({r, 24'h000000, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  task src_drive(input logic [2:0] v, input int n);
    req <= v;
    repeat (n) @(posedge clk_i);
    req <= 3'h0;
  endtask : src_drive

  task pins(input logic [3:0] ex);
    repeat (2) @(posedge clk_i);
    chk({30'h0, tq, tqe, nq, nqe}, {30'h0, ex});
  endtask : pins

  task wait_pin(input logic v);
    do @(posedge clk_i); while (tq !== v);
  endtask : wait_pin

  // divided pulse sets, a one-cycle pin pulse resets; rises are pulse-aligned
  task div_meas(input logic [2:0] s);
    int t1;
    axi_wr(srl_pkg::OFF_MAIN, {1'b1, s, 4'h8}, srl_pkg::RESP_OKAY);
    axi_wr(srl_pkg::OFF_SRC, 8'h48, srl_pkg::RESP_OKAY);
    src_drive(3'h4, 1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    t0 = cyc;
    src_drive(3'h4, 1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    t1 = cyc;
    chk(34'(t1 - t0), 34'(4 << s));
  endtask : div_meas

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [7:0] r;
    void'($urandom(53676));
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    axi_rd(srl_pkg::OFF_MAIN, 8'h00, srl_pkg::RESP_OKAY);
    axi_rd(srl_pkg::OFF_SRC, 8'h00, srl_pkg::RESP_OKAY);
    axi_rd(4'hC, 8'h00, srl_pkg::RESP_DECERR);
    axi_wr(4'hC, 8'hFF, srl_pkg::RESP_DECERR);
    // a write with byte 0 strobe low is answered but changes nothing
    wstrb <= 4'h0;
    axi_wr(srl_pkg::OFF_MAIN, 8'hFF, srl_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(srl_pkg::OFF_MAIN, 8'h00, srl_pkg::RESP_OKAY);
    axi_rd(srl_pkg::OFF_STAT, 8'h00, srl_pkg::RESP_OKAY);
    axi_wr(srl_pkg::OFF_MAIN, 8'h81, srl_pkg::RESP_OKAY);
    axi_rd(srl_pkg::OFF_STAT, 8'h00, srl_pkg::RESP_OKAY);
    axi_wr(srl_pkg::OFF_MAIN, 8'h8E, srl_pkg::RESP_OKAY);
    axi_rd(srl_pkg::OFF_STAT, 8'h01, srl_pkg::RESP_OKAY);
    axi_rd(srl_pkg::OFF_MAIN, 8'h8C, srl_pkg::RESP_OKAY);
    pins(4'hD);
    axi_wr(srl_pkg::OFF_MAIN, 8'h8F, srl_pkg::RESP_OKAY);
    axi_rd(srl_pkg::OFF_STAT, 8'h00, srl_pkg::RESP_OKAY);
    pins(4'h7);
    axi_wr(srl_pkg::OFF_MAIN, 8'h82, srl_pkg::RESP_OKAY);
    axi_rd(srl_pkg::OFF_STAT, 8'h01, srl_pkg::RESP_OKAY);
    pins(4'h0);
    axi_wr(srl_pkg::OFF_MAIN, 8'h0C, srl_pkg::RESP_OKAY);
    pins(4'h0);
    r = 8'($urandom());
    axi_wr(srl_pkg::OFF_SRC, r, srl_pkg::RESP_OKAY);
    req <= 3'($urandom());
    repeat (8) @(posedge clk_i);
    req <= 3'h0;
    axi_rd(srl_pkg::OFF_SRC, r, srl_pkg::RESP_OKAY);
    axi_rd(srl_pkg::OFF_STAT, 8'h01, srl_pkg::RESP_OKAY);
    axi_wr(srl_pkg::OFF_MAIN, 8'h80, srl_pkg::RESP_OKAY);
    // each source alone: pin, divided pulse, comparator 2, comparator 1
    for (int i = 0; i < 4; i++) begin
      axi_wr(srl_pkg::OFF_SRC, 8'h08 >> i, srl_pkg::RESP_OKAY);
      src_drive(RQ[i], 6);
      axi_rd(srl_pkg::OFF_STAT, 8'h00, srl_pkg::RESP_OKAY);
      axi_wr(srl_pkg::OFF_SRC, 8'h80 >> i, srl_pkg::RESP_OKAY);
      src_drive(RQ[i], 6);
      axi_rd(srl_pkg::OFF_STAT, 8'h01, srl_pkg::RESP_OKAY);
    end
    // cmp1 clears, then cmp2 alone sets; the single variant must stay clear
    axi_wr(srl_pkg::OFF_SRC, 8'h21, srl_pkg::RESP_OKAY);
    src_drive(3'h1, 6);
    axi_rd(srl_pkg::OFF_STAT, 8'h00, srl_pkg::RESP_OKAY);
    src_drive(3'h2, 6);
    axi_rd(srl_pkg::OFF_STAT, 8'h01, srl_pkg::RESP_OKAY);
    for (int s = 1; s < 8; s++) div_meas(3'(s));
    report_and_stop();
  end
endmodule : set_reset_latch_control_tb
